// file: hdl/sepi_pkg.sv
// Purpose: Constants for the serial EEPROM pin interface
// Assumes: 40 MHz aclk, serial clock sampled as a plain input
// Notes:   Status layout: b7 lock, b3 size hi, b2 size lo, b1 latch, b0 busy
package sepi_pkg;
   localparam logic [7:0] CMD_SET_LATCH   = 8'h06;
   localparam logic [7:0] CMD_CLR_LATCH   = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_WRITE_STAT  = 8'h01;
   localparam logic [7:0] CMD_READ_ARRAY  = 8'h03;
   localparam logic [7:0] CMD_WRITE_ARRAY = 8'h02;
   localparam int         BIT_BUSY        = 0;
   localparam int         BIT_LATCH       = 1;
   localparam int         BIT_SIZE_LO     = 2;
   localparam int         BIT_SIZE_HI     = 3;
   localparam int         BIT_LOCK        = 7;
   localparam logic [2:0] NV_RESET        = 3'h0;
   localparam int         CLK_HZ          = 40000000;
   localparam int         WRITE_TIME_US   = 5000;
   localparam int         WRITE_CYCLES    = (WRITE_TIME_US * (CLK_HZ / 1000000));
   localparam logic [31:0] AXI_OFS_STATUS = 32'h0000_0000;
   localparam logic [31:0] AXI_OFS_LAST   = 32'h0000_0004;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   typedef enum logic [3:0] {
      ST_WAIT_SEL = 4'h1,
      ST_OPCODE   = 4'h2,
      ST_BODY     = 4'h4,
      ST_IGNORE   = 4'h8
   } sepi_state_t;
endpackage

// file: hdl/sepi_top.sv
// Purpose: Device-side serial pin front end of a small serial EEPROM
// Assumes: Serial pins asynchronous to aclk, serial clock well below aclk/4
// Notes:   Array data is out of scope; array reads shift zeros
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module sepi_top
   import sepi_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
)(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Serial pins
   input  wire logic        ser_clk,
   input  wire logic        ser_sel_n,
   input  wire logic        ser_din,
   input  wire logic        ser_pause_n,
   input  wire logic        ser_wp_n,
   output logic             ser_dout,
   output logic             ser_dout_oe,
   output logic             standby,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // Two-flop synchronisers, stage 1 read only by stage 2
   logic [4:0] s1_r, s2_r, s3_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Select stage resets low: a select held low since power-up gives no edge
         s1_r <= 5'h1a;
         s2_r <= 5'h1a;
         s3_r <= 5'h1a;
      end
      else
      begin
         s1_r <= {ser_wp_n, ser_pause_n, ser_sel_n, ser_din, ser_clk};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic clk_s, din_s, sel_n_s, pause_n_s, wp_n_s;
   assign {wp_n_s, pause_n_s, sel_n_s, din_s, clk_s} = s2_r;
   logic clk_rise, clk_fall, sel_fall, sel_rise, active;
   assign active   = !sel_n_s && pause_n_s;
   assign clk_rise = clk_s && !s3_r[0] && active;
   assign clk_fall = !clk_s && s3_r[0] && active;
   assign sel_fall = !sel_n_s && s3_r[2];
   assign sel_rise = sel_n_s && !s3_r[2];

   // Frame state
   sepi_state_t st_r, st_nxt;
   logic        armed_r, armed_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic [7:0]  sh_r, sh_nxt;
   logic [7:0]  op_r, op_nxt;
   logic [7:0]  tx_r, tx_nxt;
   logic        nbytes_r, nbytes_nxt;
   logic        wrdone_r, wrdone_nxt;
   logic        dout_r, dout_nxt;
   logic        oe_r, oe_nxt;
   logic        drv_r, drv_nxt;
   logic        latch_r, latch_nxt;
   logic [2:0]  nv_r, nv_nxt;
   logic [2:0]  nvnew_r, nvnew_nxt;
   logic        busy_r, busy_nxt;
   logic        busy_st_r, busy_st_nxt;
   logic [22:0] wcnt_r, wcnt_nxt;
   logic        stby_r, stby_nxt;
   logic [7:0]  status;
   logic [7:0]  last_op_r, last_op_nxt;
   logic [7:0]  sh_in;
   logic        hw_locked;

   assign status = {nv_r[2], 3'h0, nv_r[1], nv_r[0], latch_r, busy_r};
   assign hw_locked = nv_r[2] && !wp_n_s;
   assign sh_in = {sh_r[6:0], din_s};

   always_comb
   begin
      st_nxt      = st_r;
      armed_nxt   = armed_r;
      cnt_nxt     = cnt_r;
      sh_nxt      = sh_r;
      op_nxt      = op_r;
      tx_nxt      = tx_r;
      nbytes_nxt  = nbytes_r;
      wrdone_nxt  = wrdone_r;
      dout_nxt    = dout_r;
      drv_nxt     = drv_r;
      latch_nxt   = latch_r;
      nv_nxt      = nv_r;
      nvnew_nxt   = nvnew_r;
      busy_nxt    = busy_r;
      busy_st_nxt = busy_st_r;
      wcnt_nxt    = wcnt_r;
      stby_nxt    = sel_n_s && !busy_r;
      last_op_nxt = last_op_r;
      if (busy_r)
      begin
         if (wcnt_r >= 23'(WRITE_CYC - 1))
         begin
            busy_nxt  = 1'b0;
            latch_nxt = 1'b0;
            if (busy_st_r)
               nv_nxt = nvnew_r;
         end
         else
            wcnt_nxt = wcnt_r + 23'h1;
      end
      if (sel_fall)
      begin
         armed_nxt = 1'b1;
         st_nxt    = ST_OPCODE;
      end
      if (sel_n_s)
      begin
         st_nxt = armed_r ? ST_OPCODE : ST_WAIT_SEL;
         cnt_nxt = 3'h0;
         nbytes_nxt = 1'b0;
         wrdone_nxt = 1'b0;
         drv_nxt = 1'b0;
      end
      if (sel_rise && st_r != ST_IGNORE && !busy_r)
      begin
         if (op_r == CMD_SET_LATCH && !wrdone_r && st_r == ST_BODY)
            latch_nxt = 1'b1;
         if (op_r == CMD_CLR_LATCH && st_r == ST_BODY)
            latch_nxt = 1'b0;
         if (op_r == CMD_WRITE_STAT && wrdone_r && cnt_r == 3'h0 && latch_r
             && !hw_locked)
         begin
            busy_nxt    = 1'b1;
            busy_st_nxt = 1'b1;
            wcnt_nxt    = 23'h0;
         end
         if (op_r == CMD_WRITE_ARRAY && nbytes_r && cnt_r == 3'h0 && latch_r)
         begin
            busy_nxt    = 1'b1;
            busy_st_nxt = 1'b0;
            wcnt_nxt    = 23'h0;
         end
      end
      if (!sel_n_s && st_r != ST_WAIT_SEL && st_r != ST_IGNORE)
      begin
         if (clk_rise)
         begin
            sh_nxt  = sh_in;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7)
            begin
               if (st_r == ST_OPCODE)
               begin
                  op_nxt = sh_in;
                  last_op_nxt = sh_in;
                  unique case (sh_in)
                     CMD_SET_LATCH, CMD_CLR_LATCH, CMD_WRITE_STAT,
                     CMD_READ_ARRAY, CMD_WRITE_ARRAY:
                        st_nxt = ST_BODY;
                     CMD_READ_STATUS:
                     begin
                        st_nxt = ST_BODY;
                        tx_nxt = status;
                     end
                     default:
                        st_nxt = ST_IGNORE;
                  endcase
               end
               else
               begin
                  nbytes_nxt = 1'b1;
                  if (op_r == CMD_WRITE_STAT && !wrdone_r)
                  begin
                     wrdone_nxt = 1'b1;
                     nvnew_nxt = {sh_in[BIT_LOCK], sh_in[BIT_SIZE_HI],
                                  sh_in[BIT_SIZE_LO]};
                  end
                  else if (op_r == CMD_WRITE_STAT)
                     wrdone_nxt = 1'b0;
                  if (op_r == CMD_READ_STATUS)
                     tx_nxt = status;
               end
            end
         end
         if (clk_fall && st_r == ST_BODY)
         begin
            drv_nxt = (op_r == CMD_READ_STATUS) || (op_r == CMD_READ_ARRAY);
            dout_nxt = (op_r == CMD_READ_STATUS) ? tx_r[3'h7 - cnt_r] : 1'b0;
         end
      end
      // Drive intent survives a pause, so the output comes back on release
      oe_nxt = drv_nxt && active;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r      <= ST_WAIT_SEL;
         armed_r   <= 1'b0;
         cnt_r     <= 3'h0;
         sh_r      <= 8'h00;
         op_r      <= 8'h00;
         tx_r      <= 8'h00;
         nbytes_r  <= 1'b0;
         wrdone_r  <= 1'b0;
         dout_r    <= 1'b0;
         oe_r      <= 1'b0;
         drv_r     <= 1'b0;
         latch_r   <= 1'b0;
         nv_r      <= NV_RESET;
         nvnew_r   <= NV_RESET;
         busy_r    <= 1'b0;
         busy_st_r <= 1'b0;
         wcnt_r    <= 23'h0;
         stby_r    <= 1'b1;
         last_op_r <= 8'h00;
      end
      else
      begin
         st_r      <= st_nxt;
         armed_r   <= armed_nxt;
         cnt_r     <= cnt_nxt;
         sh_r      <= sh_nxt;
         op_r      <= op_nxt;
         tx_r      <= tx_nxt;
         nbytes_r  <= nbytes_nxt;
         wrdone_r  <= wrdone_nxt;
         dout_r    <= dout_nxt;
         oe_r      <= oe_nxt;
         drv_r     <= drv_nxt;
         latch_r   <= latch_nxt;
         nv_r      <= nv_nxt;
         nvnew_r   <= nvnew_nxt;
         busy_r    <= busy_nxt;
         busy_st_r <= busy_st_nxt;
         wcnt_r    <= wcnt_nxt;
         stby_r    <= stby_nxt;
         last_op_r <= last_op_nxt;
      end
   end
   assign ser_dout    = dout_r;
   assign ser_dout_oe = oe_r;
   assign standby     = stby_r;

   // AXI4-Lite: read-only status view; writes answer SLVERR
   logic       aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic       awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, ardy_r, ardy_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
   logic [31:0] rd_r, rd_nxt;
   always_comb
   begin
      aw_nxt = aw_r;
      w_nxt  = w_r;
      bv_nxt = bv_r;
      br_nxt = br_r;
      rv_nxt = rv_r;
      rr_nxt = rr_r;
      rd_nxt = rd_r;
      // Readies are registered: one idle cycle per request, no comb path to pins
      awrdy_nxt = s_axi_awvalid && !awrdy_r && !aw_r && !bv_r;
      wrdy_nxt  = s_axi_wvalid && !wrdy_r && !w_r && !bv_r;
      ardy_nxt  = s_axi_arvalid && !ardy_r && !rv_r;
      if (s_axi_awvalid && awrdy_r)
         aw_nxt = 1'b1;
      if (s_axi_wvalid && wrdy_r)
         w_nxt = 1'b1;
      if (aw_r && w_r && !bv_r)
      begin
         bv_nxt = 1'b1;
         br_nxt = RESP_SLVERR;
      end
      if (bv_r && s_axi_bready)
      begin
         bv_nxt = 1'b0;
         aw_nxt = 1'b0;
         w_nxt  = 1'b0;
      end
      if (s_axi_arvalid && ardy_r)
      begin
         rv_nxt = 1'b1;
         rr_nxt = RESP_OKAY;
         if (s_axi_araddr[31:2] == AXI_OFS_STATUS[31:2])
            rd_nxt = {24'h0, status};
         else if (s_axi_araddr[31:2] == AXI_OFS_LAST[31:2])
            rd_nxt = {16'h0, 4'h0, st_r, last_op_r};
         else
         begin
            rd_nxt = 32'h0;
            rr_nxt = RESP_SLVERR;
         end
      end
      else if (rv_r && s_axi_rready)
         rv_nxt = 1'b0;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_r <= 1'b0;
         w_r  <= 1'b0;
         bv_r <= 1'b0;
         br_r <= RESP_OKAY;
         rv_r <= 1'b0;
         rr_r <= RESP_OKAY;
         rd_r <= 32'h0;
         awrdy_r <= 1'b0;
         wrdy_r  <= 1'b0;
         ardy_r  <= 1'b0;
      end
      else
      begin
         aw_r <= aw_nxt;
         w_r  <= w_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rr_r <= rr_nxt;
         rd_r <= rd_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r  <= wrdy_nxt;
         ardy_r  <= ardy_nxt;
      end
   end
   assign s_axi_awready = awrdy_r;
   assign s_axi_wready  = wrdy_r;
   assign s_axi_bvalid  = bv_r;
   assign s_axi_bresp   = br_r;
   assign s_axi_arready = ardy_r;
   assign s_axi_rvalid  = rv_r;
   assign s_axi_rresp   = rr_r;
   assign s_axi_rdata   = rd_r;

   // Checks
   AST_OE_OFF_DESEL: assert property (@(posedge aclk) disable iff (!aresetn)
      sel_n_s |=> !oe_r) else $error("output driven while deselected");
   AST_OE_OFF_PAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
      !pause_n_s |=> !oe_r) else $error("output driven while paused");
   AST_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn)
      (sel_n_s && !busy_r) |=> stby_r) else $error("no standby");
   AST_ACTIVE: assert property (@(posedge aclk) disable iff (!aresetn)
      !sel_n_s |=> !stby_r) else $error("standby while selected");
   AST_ARMED: assert property (@(posedge aclk) disable iff (!aresetn)
      !armed_r |-> st_r == ST_WAIT_SEL) else $error("traffic before select edge");
   AST_PAUSE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      (!pause_n_s && !sel_n_s) |=> $stable(cnt_r) && $stable(sh_r))
      else $error("shift moved while paused");
   AST_DOUT_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(dout_r) |-> $past(clk_fall)) else $error("output not on fall");
   AST_SHIFT_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_rise && st_r == ST_OPCODE && !sel_n_s) |=> sh_r[0] == $past(din_s))
      else $error("input not sampled on rise");
   AST_BAD_OP: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r == ST_IGNORE |-> !oe_r) else $error("ignored frame drives output");
   AST_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
      (hw_locked && !busy_r) |=> !(busy_r && busy_st_r))
      else $error("status write while locked");
   AST_BUSY_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
      busy_r |-> wcnt_r < 23'(WRITE_CYC)) else $error("write cycle too long");
endmodule // sepi_top

// file: tb/sepi_host_model.sv
// Purpose: Host side of the serial pins, clock idle low
// Assumes: 200 ns link clock, running only inside frames
// Notes:   Select starts low, so power-up shows no select edge
`timescale 1ns/1ps
module sepi_host_model (
   // Watch clock
   input  wire logic aclk,
   // Pins toward the device
   output logic      ser_clk,
   output logic      ser_sel_n,
   output logic      ser_din,
   output logic      ser_pause_n,
   output logic      ser_wp_n,
   input  wire logic ser_dout,
   input  wire logic ser_dout_oe
);
   logic [7:0] rx_byte;
   logic       q_last;
   int         off_cnt;
   bit         z_viol;
   event       got;
   // Released line shows the inverse of its last level
   wire        q_line = ser_dout_oe ? ser_dout : ~q_last;
   always @(ser_dout or ser_dout_oe)
      if (ser_dout_oe)
         q_last = ser_dout;
   // Output must let go once deselected or paused
   always @(posedge aclk)
   begin
      off_cnt <= (ser_sel_n || !ser_pause_n) ? off_cnt + 1 : 0;
      if (off_cnt > 6 && ser_dout_oe !== 1'b0)
         z_viol <= 1'b1;
   end
   initial
   begin
      ser_clk = 1'b0;
      ser_sel_n = 1'b0;
      ser_din = 1'b0;
      ser_pause_n = 1'b1;
      ser_wp_n = 1'b1;
      q_last = 1'b0;
   end
   task automatic select();
      #37 ser_sel_n = 1'b1;
      #150 ser_sel_n = 1'b0;
      #150;
   endtask
   task automatic deselect();
      #100 ser_sel_n = 1'b1;
      ser_din = ~ser_din;
      #200;
   endtask
   // Pause only inside a frame, clock low; wiggles must be ignored
   task automatic hold(input logic [7:0] junk);
      // Let the last clock fall pass the synchroniser before pausing
      #60 ser_pause_n = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         #100 ser_din = junk[k];
         ser_clk = ~ser_clk;
      end
      #100 ser_pause_n = 1'b1;
      #100;
   endtask
   // Opcode first, MSB first; sample late in the high phase
   task automatic shift(input logic [7:0] tx, input logic [7:0] junk,
                        input int pause_at, input bit chk);
      for (int i = 7; i >= 0; i--)
      begin
         if (i == pause_at)
            hold(junk);
         ser_din = tx[i];
         #100 ser_clk = 1'b1;
         #95 rx_byte[i] = q_line;
         #5 ser_clk = 1'b0;
      end
      if (chk)
         ->got;
   endtask
   task automatic set_wp(input logic v);
      ser_wp_n = v;
      #200;
   endtask
endmodule // sepi_host_model

// file: tb/test_serial_eeprom_pin_interface.sv
// Purpose: Self-checking bench of the serial pin front end
// Assumes: Short write cycle parameter, AXI4-Lite status reads
// Notes:   Expectations are queued by drivers, checked by monitors
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module test_serial_eeprom_pin_interface;
   import sepi_pkg::*;
   localparam int WC = 50;
   logic        aclk, aresetn, ser_dout, ser_dout_oe, standby;
   wire         ser_clk, ser_sel_n, ser_din, ser_pause_n, ser_wp_n;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rng, r;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  bad, e8, ser_q[$];
   logic [33:0] er, rd_q[$];
   logic [1:0]  wr_q[$];
   int          n_mismatch, checks_done, cyc;
   sepi_top #(.WRITE_CYC(WC)) dut (.aclk, .aresetn, .ser_clk, .ser_sel_n, .ser_din,
      .ser_pause_n, .ser_wp_n, .ser_dout, .ser_dout_oe, .standby, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   sepi_host_model host (.aclk, .ser_clk, .ser_sel_n, .ser_din, .ser_pause_n,
      .ser_wp_n, .ser_dout, .ser_dout_oe);
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      rd_q.push_back({e, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      wr_q.push_back(e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (s_axi_wready !== 1'b1);
            s_axi_wvalid <= 1'b0;
         end
      join
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic st(input logic [7:0] e);
      axi_rd(AXI_OFS_STATUS, {24'h000000, e}, RESP_OKAY);
   endtask
   task automatic cmd(input logic [31:0] b, input int n);
      host.select();
      for (int i = 0; i < n; i++)
         host.shift(b[31-8*i -: 8], 8'h00, 8, 1'b0);
      host.deselect();
   endtask
   always @(posedge aclk)
   begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      begin
         er = rd_q.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, er, "register read")
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      begin
         eb = wr_q.pop_front();
         `CHK(s_axi_bresp, eb, "register write response")
      end
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   always @(host.got)
   begin
      e8 = ser_q.pop_front();
      `CHK(host.rx_byte, e8, "serial byte")
   end
   initial
   begin
      rng = 32'h0000_0063;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK(standby, 1'b0, "active with select low from power-up")
      axi_rd(AXI_OFS_LAST, {20'h00000, ST_WAIT_SEL, 8'h00}, RESP_OKAY);
      axi_rd(32'h0000_0008, 32'h0000_0000, RESP_SLVERR);
      axi_wr(AXI_OFS_STATUS, xs(), RESP_SLVERR);
      // Select low since power-up: no edge, so traffic is ignored
      host.shift(CMD_SET_LATCH, 8'h00, 8, 1'b0);
      host.deselect();
      st(8'h00);
      cmd({CMD_SET_LATCH, 24'h000000}, 1);
      st(8'h02);
      host.select();
      `CHK(standby, 1'b0, "active while selected")
      host.shift(CMD_READ_STATUS, 8'h00, 8, 1'b0);
      r = xs();
      ser_q.push_back(8'h02);
      host.shift(r[7:0], r[15:8], 3, 1'b1);
      ser_q.push_back(8'h02);
      host.shift(r[23:16], 8'h00, 8, 1'b1);
      host.deselect();
      cmd({CMD_CLR_LATCH, 24'h000000}, 1);
      st(8'h00);
      do bad = 8'(xs()); while (bad inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
      cmd({bad, CMD_SET_LATCH, 16'h0000}, 2);
      st(8'h00);
      cmd({CMD_SET_LATCH, 24'h000000}, 1);
      cmd({CMD_WRITE_STAT, 8'h8c, 16'h0000}, 2);
      `CHK(standby, 1'b0, "awake while writing")
      st(8'h03);
      repeat (WC + 20) @(posedge aclk);
      st(8'h8c);
      `CHK(standby, 1'b1, "standby after write")
      host.set_wp(1'b0);
      cmd({CMD_SET_LATCH, 24'h000000}, 1);
      cmd({CMD_WRITE_STAT, 8'h00, 16'h0000}, 2);
      repeat (WC + 20) @(posedge aclk);
      st(8'h8e);
      host.set_wp(1'b1);
      cmd({CMD_WRITE_STAT, 8'h04, 16'h0000}, 2);
      repeat (WC + 20) @(posedge aclk);
      st(8'h04);
      cmd({CMD_SET_LATCH, 24'h000000}, 1);
      cmd({CMD_WRITE_ARRAY, 16'h0000, r[31:24]}, 4);
      st(8'h07);
      repeat (WC + 20) @(posedge aclk);
      st(8'h04);
      `CHK(host.z_viol, 1'b0, "output driven while off")
      tally_and_finish();
   end
endmodule // test_serial_eeprom_pin_interface
